// File: hdl/diag_led_defs.svh
/*
 * Constants for the diagnostic indicator encoder: colours, error codes, flash timing.
 * Assumes a 10 MHz system clock; included by bare name.
 */
`ifndef DIAG_LED_DEFS_SVH
`define DIAG_LED_DEFS_SVH

// colour encodings {red, green}; orange is both lit
`define COL_OFF 2'h0
`define COL_GREEN 2'h1
`define COL_RED 2'h2
`define COL_ORANGE 2'h3

// terminal-bus error codes
`define ERR_INTERFERENCE 4'h0
`define ERR_SETTINGS 4'h1
`define ERR_RESERVED 4'h2
`define ERR_COMMAND 4'h3
`define ERR_BREAK 4'h4
`define ERR_REGCOMM 4'h5
`define ARG_CHECKSUM 8'h00
`define ARG_TABLE_OVF 8'h01
`define ARG_UNKNOWN_TYPE 8'h02

// timing: clock rate, flash half period in ms, gap between groups in phases
`define CLK_HZ 10000000
`define PHASE_MS 250
`define PHASE_CYCLES ((`CLK_HZ / 1000) * `PHASE_MS)
`define GAP_PHASES 5'h04
`define CNT_W 24
`define CNT_ONE 24'h000001
`define CNT_ZERO 24'h000000
`define PULSE_ONE 9'h001
`define PULSE_ZERO 9'h000
`define GAP_ZERO 5'h00
`define GAP_ONE 5'h01

`endif

// File: hdl/diag_led_pkg.sv
/*
 * Types shared by the diagnostic indicator encoder.
 * Assumes the defs header is included where the constants are needed.
 */
package diag_led_pkg;

	typedef enum logic [2:0] {
		FL_IDLE,
		FL_CODE,
		FL_GAP1,
		FL_ARG,
		FL_GAP2
	} flash_state_t;

	typedef enum logic [2:0] {
		BUS_SEARCH,
		BUS_WAIT_CFG,
		BUS_RUN,
		BUS_FAULT
	} bus_mode_t;

endpackage

// File: hdl/flash_if.sv
/*
 * Interface carrying a red flash request and the flashing output between
 * the top module and its flash sequencer.
 * Assumes a single system clock.
 */
`timescale 1ns/1ps
`default_nettype none

interface flash_if;
	logic active;
	logic [3:0] code;
	logic [7:0] arg;
	logic has_arg;
	logic tick;
	logic lamp;

	modport owner (output active, output code, output arg, output has_arg, output tick,
		input lamp);
	modport seq (input active, input code, input arg, input has_arg, input tick,
		output lamp);
endinterface

`default_nettype wire

// File: hdl/flash_seq.sv
/*
 * Red flash sequencer: pulse group for the code, gap, pulse group for
 * the argument when has_arg is set, gap, repeating while the fault request stands.
 * Assumes tick is a one-cycle enable per flash phase.
 */
`timescale 1ns/1ps
`default_nettype none
`include "diag_led_defs.svh"

module flash_seq (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_arst_n,
	// request and lamp
	flash_if.seq f
);

	typedef struct packed {
		diag_led_pkg::flash_state_t st;
		logic [8:0] pulses;
		logic [4:0] gap;
		logic lamp;
	} seq_state_t;

	seq_state_t s_q;
	seq_state_t s_d;

	// code n flashes n+1 times so code 0 is still visible
	function automatic logic [8:0] pulse_count(input logic [7:0] v);
		pulse_count = {1'b0, v} + `PULSE_ONE;
	endfunction

	always_comb
	begin
		s_d = s_q;
		if (!f.active)
		begin
			s_d.st = diag_led_pkg::FL_IDLE;
			s_d.lamp = 1'b0;
		end
		else if (f.tick)
		begin
			case (s_q.st)
				diag_led_pkg::FL_IDLE:
				begin
					s_d.st = diag_led_pkg::FL_CODE;
					s_d.pulses = pulse_count({4'h0, f.code});
					s_d.lamp = 1'b1;
				end
				diag_led_pkg::FL_CODE, diag_led_pkg::FL_ARG:
				begin
					if (s_q.lamp)
					begin
						s_d.lamp = 1'b0;
						s_d.pulses = s_q.pulses - `PULSE_ONE;
					end
					else if (s_q.pulses != `PULSE_ZERO)
						s_d.lamp = 1'b1;
					else
					begin
						s_d.st = (s_q.st == diag_led_pkg::FL_CODE) ?
							diag_led_pkg::FL_GAP1 : diag_led_pkg::FL_GAP2;
						s_d.gap = `GAP_PHASES;
					end
				end
				diag_led_pkg::FL_GAP1:
				begin
					if (s_q.gap > `GAP_ONE)
						s_d.gap = s_q.gap - `GAP_ONE;
					else if (f.has_arg)
					begin
						s_d.st = diag_led_pkg::FL_ARG;
						s_d.pulses = pulse_count(f.arg);
						s_d.lamp = 1'b1;
					end
					else
					begin
						s_d.st = diag_led_pkg::FL_GAP2;
						s_d.gap = `GAP_PHASES;
					end
				end
				diag_led_pkg::FL_GAP2:
				begin
					if (s_q.gap > `GAP_ONE)
						s_d.gap = s_q.gap - `GAP_ONE;
					else
						s_d.st = diag_led_pkg::FL_IDLE;
				end
				default:
				begin
					s_d.st = diag_led_pkg::FL_IDLE;
					s_d.lamp = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
			s_q <= '{st: diag_led_pkg::FL_IDLE, pulses: `PULSE_ZERO, gap: `GAP_ZERO,
				lamp: 1'b0};
		else
			s_q <= s_d;
	end

	assign f.lamp = s_q.lamp;

endmodule // flash_seq

`default_nettype wire

// File: hdl/diag_led_encoder.sv
/*
 * Diagnostic indicator encoder: drives fieldbus, program and terminal-bus
 * indicators as off/green/orange/red, with red flash codes.
 * Assumes status inputs come from firmware logic on the system clock, so
 * they are used unsynchronised.
 */
`timescale 1ns/1ps
`default_nettype none
`include "diag_led_defs.svh"

module diag_led_encoder (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_arst_n,
	// fieldbus status
	input wire logic i_bus_rate_found,
	input wire logic i_bus_data_ok,
	input wire logic i_bus_fault,
	input wire logic [3:0] i_bus_err_code,
	input wire logic [7:0] i_bus_err_arg,
	// program status
	input wire logic i_prog_running,
	input wire logic i_prog_loaded,
	input wire logic i_prog_boot_image,
	input wire logic i_prog_boot_creating,
	input wire logic i_prog_overrun_some,
	input wire logic i_prog_overrun_all,
	// terminal bus status
	input wire logic i_io_check_done,
	input wire logic i_io_check_ok,
	input wire logic i_io_cycling,
	input wire logic i_io_access,
	input wire logic i_io_ev_interference,
	input wire logic i_io_ev_checksum,
	input wire logic i_io_ev_table_ovf,
	input wire logic i_io_ev_unknown_type,
	input wire logic i_io_ev_command,
	input wire logic i_io_ev_break,
	input wire logic i_io_ev_regcomm,
	input wire logic [7:0] i_io_ev_terminal,
	input wire logic i_io_fault_clear,
	// indicators, {red, green}
	output logic [1:0] o_bus_led,
	output logic [1:0] o_prog_led,
	output logic [1:0] o_io_led,
	// display mirror of active fault
	output logic o_disp_valid,
	output logic o_disp_is_io,
	output logic [3:0] o_disp_code,
	output logic [7:0] o_disp_arg
);

	typedef struct packed {
		logic [`CNT_W-1:0] div;
		logic tick;
		logic slow;
		logic io_fault;
		logic [3:0] io_code;
		logic [7:0] io_arg;
		logic io_has_arg;
		logic io_started;
		logic [1:0] bus_led;
		logic [1:0] prog_led;
		logic [1:0] io_led;
		logic disp_valid;
		logic disp_is_io;
		logic [3:0] disp_code;
		logic [7:0] disp_arg;
	} top_state_t;

	top_state_t s_q;
	top_state_t s_d;

	flash_if bus_f ();
	flash_if io_f ();

	flash_seq u_bus_flash (
		.i_clk_sys(i_clk_sys),
		.i_arst_n(i_arst_n),
		.f(bus_f.seq)
	);

	flash_seq u_io_flash (
		.i_clk_sys(i_clk_sys),
		.i_arst_n(i_arst_n),
		.f(io_f.seq)
	);

	assign bus_f.active = i_bus_fault;
	assign bus_f.code = i_bus_err_code;
	assign bus_f.arg = i_bus_err_arg;
	assign bus_f.has_arg = 1'b1;
	assign bus_f.tick = s_q.tick;
	assign io_f.active = s_q.io_fault;
	assign io_f.code = s_q.io_code;
	assign io_f.arg = s_q.io_arg;
	assign io_f.has_arg = s_q.io_has_arg;
	assign io_f.tick = s_q.tick;

	// red lamp of a flashing indicator, from the sequencer
	function automatic logic [1:0] red_if(input logic on);
		red_if = on ? `COL_RED : `COL_OFF;
	endfunction

	always_comb
	begin
		s_d = s_q;
		// one flash phase per tick
		s_d.tick = 1'b0;
		if (s_q.div == `CNT_W'(`PHASE_CYCLES - 1))
		begin
			s_d.div = `CNT_ZERO;
			s_d.tick = 1'b1;
			s_d.slow = ~s_q.slow;
		end
		else
			s_d.div = s_q.div + `CNT_ONE;

		// first event latched; later events lost until cleared, keeps the code stable
		if (!s_q.io_fault)
		begin
			if (i_io_ev_interference)
			begin
				s_d.io_fault = 1'b1;
				s_d.io_code = `ERR_INTERFERENCE;
				s_d.io_arg = 8'h00;
				s_d.io_has_arg = 1'b0;
			end
			else if (i_io_ev_checksum)
			begin
				s_d.io_fault = 1'b1;
				s_d.io_code = `ERR_SETTINGS;
				s_d.io_arg = `ARG_CHECKSUM;
				s_d.io_has_arg = 1'b1;
			end
			else if (i_io_ev_table_ovf)
			begin
				s_d.io_fault = 1'b1;
				s_d.io_code = `ERR_SETTINGS;
				s_d.io_arg = `ARG_TABLE_OVF;
				s_d.io_has_arg = 1'b1;
			end
			// unknown data type; reserved code never raised
			else if (i_io_ev_unknown_type)
			begin
				s_d.io_fault = 1'b1;
				s_d.io_code = `ERR_SETTINGS;
				s_d.io_arg = `ARG_UNKNOWN_TYPE;
				s_d.io_has_arg = 1'b1;
			end
			else if (i_io_ev_command)
			begin
				s_d.io_fault = 1'b1;
				s_d.io_code = `ERR_COMMAND;
				s_d.io_arg = 8'h00;
				s_d.io_has_arg = 1'b1;
			end
			else if (i_io_ev_break)
			begin
				s_d.io_fault = 1'b1;
				s_d.io_code = `ERR_BREAK;
				s_d.io_arg = i_io_ev_terminal;
				s_d.io_has_arg = 1'b1;
			end
			else if (i_io_ev_regcomm)
			begin
				s_d.io_fault = 1'b1;
				s_d.io_code = `ERR_REGCOMM;
				s_d.io_arg = i_io_ev_terminal;
				s_d.io_has_arg = 1'b1;
			end
		end
		// clear only when no new event arrives that cycle
		else if (i_io_fault_clear && !(i_io_ev_interference || i_io_ev_checksum ||
			i_io_ev_table_ovf || i_io_ev_unknown_type || i_io_ev_command ||
			i_io_ev_break || i_io_ev_regcomm))
			s_d.io_fault = 1'b0;

		if (i_io_check_done && i_io_check_ok)
			s_d.io_started = 1'b1;

		if (i_bus_fault)
			s_d.bus_led = red_if(bus_f.lamp);
		else if (i_bus_data_ok)
			s_d.bus_led = `COL_GREEN;
		else if (i_bus_rate_found)
			s_d.bus_led = `COL_ORANGE;
		else
			s_d.bus_led = `COL_OFF;

		if (!i_prog_running || !i_prog_loaded)
			s_d.prog_led = `COL_OFF;
		else if (i_prog_overrun_all)
			s_d.prog_led = `COL_RED;
		else if (i_prog_overrun_some)
			s_d.prog_led = s_q.slow ? `COL_RED : `COL_OFF;
		else if (i_prog_boot_creating)
			s_d.prog_led = s_q.slow ? `COL_ORANGE : `COL_OFF;
		else if (i_prog_boot_image)
			s_d.prog_led = `COL_GREEN;
		else
			s_d.prog_led = `COL_ORANGE;

		if (s_q.io_fault)
			s_d.io_led = red_if(io_f.lamp);
		else if (i_io_access)
			s_d.io_led = `COL_ORANGE;
		else if (i_io_cycling && s_q.io_started)
			s_d.io_led = `COL_GREEN;
		else
			s_d.io_led = `COL_OFF;

		s_d.disp_valid = s_q.io_fault | i_bus_fault;
		s_d.disp_is_io = s_q.io_fault;
		s_d.disp_code = s_q.io_fault ? s_q.io_code : (i_bus_fault ? i_bus_err_code : 4'h0);
		s_d.disp_arg = s_q.io_fault ? s_q.io_arg : (i_bus_fault ? i_bus_err_arg : 8'h00);
	end

	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign o_bus_led = s_q.bus_led;
	assign o_prog_led = s_q.prog_led;
	assign o_io_led = s_q.io_led;
	assign o_disp_valid = s_q.disp_valid;
	assign o_disp_is_io = s_q.disp_is_io;
	assign o_disp_code = s_q.disp_code;
	assign o_disp_arg = s_q.disp_arg;

endmodule // diag_led_encoder

`default_nettype wire

// File: bench/diag_led_checker.sv
/* checker: port assertions for the indicator encoder.
   assumes one clock domain and the shared defs header. */
`timescale 1ns/1ps
`default_nettype none
`include "diag_led_defs.svh"

module diag_led_checker (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_arst_n,
	// watched status
	input wire logic i_bus_rate_found,
	input wire logic i_bus_data_ok,
	input wire logic i_bus_fault,
	input wire logic i_prog_running,
	input wire logic i_prog_loaded,
	input wire logic i_prog_boot_image,
	input wire logic i_prog_boot_creating,
	input wire logic i_prog_overrun_some,
	input wire logic i_prog_overrun_all,
	input wire logic i_io_cycling,
	input wire logic i_io_access,
	input wire logic i_io_ev_interference,
	input wire logic i_io_ev_checksum,
	input wire logic i_io_ev_table_ovf,
	input wire logic i_io_ev_unknown_type,
	input wire logic i_io_ev_command,
	input wire logic i_io_ev_break,
	input wire logic i_io_ev_regcomm,
	input wire logic i_io_fault_clear,
	// watched outputs
	input wire logic [1:0] o_bus_led,
	input wire logic [1:0] o_prog_led,
	input wire logic [1:0] o_io_led,
	input wire logic o_disp_valid,
	input wire logic o_disp_is_io,
	input wire logic [3:0] o_disp_code
);
	wire logic ev_any = i_io_ev_interference | i_io_ev_checksum | i_io_ev_table_ovf
		| i_io_ev_unknown_type | i_io_ev_command | i_io_ev_break | i_io_ev_regcomm;
	wire logic io_shown = o_disp_valid & o_disp_is_io;
	logic [3:0] exp_code;

	// first event in priority order wins
	always_comb
	begin
		if (i_io_ev_interference)
			exp_code = `ERR_INTERFERENCE;
		else if (i_io_ev_checksum | i_io_ev_table_ovf | i_io_ev_unknown_type)
			exp_code = `ERR_SETTINGS;
		else if (i_io_ev_command)
			exp_code = `ERR_COMMAND;
		else if (i_io_ev_break)
			exp_code = `ERR_BREAK;
		else
			exp_code = `ERR_REGCOMM;
	end

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_arst_n);

	a_bus_search_off: assert property (!i_bus_rate_found && !i_bus_fault |=> o_bus_led == `COL_OFF)
		else $error("bus lamp not off while searching");
	a_bus_wait_orange: assert property (i_bus_rate_found && !i_bus_data_ok && !i_bus_fault
		|=> o_bus_led == `COL_ORANGE) else $error("bus lamp not orange");
	a_bus_run_green: assert property (i_bus_rate_found && i_bus_data_ok && !i_bus_fault
		|=> o_bus_led == `COL_GREEN) else $error("bus lamp not green");
	a_prog_stop_off: assert property (!i_prog_running || !i_prog_loaded
		|=> o_prog_led == `COL_OFF) else $error("program lamp not off");
	a_prog_boot_green: assert property (i_prog_running && i_prog_loaded && i_prog_boot_image
		&& !i_prog_boot_creating && !i_prog_overrun_some && !i_prog_overrun_all
		|=> o_prog_led == `COL_GREEN) else $error("program lamp not green");
	a_io_idle_off: assert property (!io_shown && !$past(ev_any) && !i_io_cycling
		&& !i_io_access |=> o_io_led == `COL_OFF) else $error("terminal lamp not off");
	a_disp_new_code: assert property (ev_any && !io_shown && !$past(ev_any)
		|=> ##1 io_shown && o_disp_code == $past(exp_code, 2)) else $error("wrong fault code");
	a_disp_first_kept: assert property (io_shown && !i_io_fault_clear
		&& !$past(i_io_fault_clear) |=> !io_shown || $stable(o_disp_code))
		else $error("latched fault replaced");
	a_io_fault_red: assert property (io_shown |-> o_io_led == `COL_OFF || o_io_led == `COL_RED)
		else $error("terminal lamp not red flash during fault");
	a_bus_fault_red: assert property (i_bus_fault |=> o_bus_led == `COL_OFF
		|| o_bus_led == `COL_RED) else $error("bus lamp not red flash during fault");
endmodule // diag_led_checker

bind diag_led_encoder diag_led_checker u_chk (.*);

`default_nettype wire

// File: bench/panel_observer.sv
/* operator model: reads the three lamps as colours.
   assumes {red, green} encoding on each lamp. */
`timescale 1ns/1ps
`default_nettype none

module panel_observer (
	// lamps
	input wire logic [1:0] i_bus_led,
	input wire logic [1:0] i_prog_led,
	input wire logic [1:0] i_io_led,
	// what the operator sees
	output logic [5:0] o_seen
);
	// each lamp read as one of four colours
	assign o_seen = {i_bus_led, i_prog_led, i_io_led};
endmodule // panel_observer

`default_nettype wire

// File: bench/tb_diag_led_encoder.sv
/* testbench: steady lamp states and fault display codes.
   assumes flash phases too long to watch, so lamps are checked steady. */
`timescale 1ns/1ps
`default_nettype none
`include "diag_led_defs.svh"

module tb_diag_led_encoder;
	logic i_clk_sys = 0, i_arst_n = 0, i_io_fault_clear = 0;
	logic i_bus_rate_found = 0, i_bus_data_ok = 0, i_bus_fault = 0;
	logic [3:0] i_bus_err_code = 4'h0;
	logic [7:0] i_bus_err_arg = 8'h00, i_io_ev_terminal = 8'h07;
	logic i_prog_running = 0, i_prog_loaded = 0, i_prog_boot_image = 0;
	logic i_prog_boot_creating = 0, i_prog_overrun_some = 0, i_prog_overrun_all = 0;
	logic i_io_check_done = 0, i_io_check_ok = 0, i_io_cycling = 0, i_io_access = 0;
	logic [6:0] ev = 7'h00;
	wire logic i_io_ev_interference = ev[0];
	wire logic i_io_ev_checksum = ev[1];
	wire logic i_io_ev_table_ovf = ev[2];
	wire logic i_io_ev_unknown_type = ev[3];
	wire logic i_io_ev_command = ev[4];
	wire logic i_io_ev_break = ev[5];
	wire logic i_io_ev_regcomm = ev[6];
	logic [1:0] o_bus_led, o_prog_led, o_io_led;
	logic o_disp_valid, o_disp_is_io;
	logic [3:0] o_disp_code;
	logic [7:0] o_disp_arg;
	logic [5:0] seen;
	logic [3:0] codes [0:6] = '{4'h0, 4'h1, 4'h1, 4'h1, 4'h3, 4'h4, 4'h5};
	logic [7:0] args [0:6] = '{8'h00, 8'h00, 8'h01, 8'h02, 8'h00, 8'h07, 8'h07};
	int mismatches = 0, checks_done = 0, cyc = 0, i;

	diag_led_encoder u_dut (.*);
	panel_observer u_panel (.i_bus_led(o_bus_led), .i_prog_led(o_prog_led),
		.i_io_led(o_io_led), .o_seen(seen));

	initial
	begin
		forever #50 i_clk_sys = ~i_clk_sys;
	end

	task automatic step(input int n);
		repeat (n) @(negedge i_clk_sys);
	endtask

	task automatic cmp_val(input logic [12:0] g, input logic [12:0] e);
		checks_done++;
		if (g !== e)
		begin
			mismatches++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask

	task automatic finish_test;
		$display("mismatches=%0d checks_done=%0d", mismatches, checks_done);
		if (mismatches == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// under a hundred cycles expected; a hang is cut short
	always @(posedge i_clk_sys)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			mismatches++;
			finish_test();
		end
	end

	// ************
	// main sequence
	// ************
	initial
	begin
		step(16);
		i_arst_n = 1;
		step(2);
		cmp_val({7'h00, seen}, 13'h0000);
		{i_io_check_done, i_io_check_ok, i_bus_rate_found, i_prog_loaded} = 4'hF;
		step(2);
		cmp_val({7'h00, seen}, {7'h00, `COL_ORANGE, `COL_OFF, `COL_OFF});
		{i_bus_data_ok, i_prog_running, i_io_cycling} = 3'h7;
		step(2);
		cmp_val({7'h00, seen}, {7'h00, `COL_GREEN, `COL_ORANGE, `COL_GREEN});
		{i_prog_boot_image, i_io_cycling, i_io_access} = 3'h5;
		step(2);
		cmp_val({7'h00, seen}, {7'h00, `COL_GREEN, `COL_GREEN, `COL_ORANGE});
		{i_prog_overrun_all, i_io_access} = 2'h2;
		step(2);
		cmp_val({7'h00, seen}, {7'h00, `COL_GREEN, `COL_RED, `COL_OFF});
		{i_prog_overrun_all, i_prog_running} = 2'h0;
		step(2);
		cmp_val({7'h00, seen}, {7'h00, `COL_GREEN, `COL_OFF, `COL_OFF});
		for (i = 0; i < 7; i++)
		begin
			ev[i] = 1'b1;
			step(1);
			ev = 7'h00;
			step(1);
			cmp_val({o_disp_is_io, o_disp_code, i > 0 ? o_disp_arg : 8'h00}, {1'b1, codes[i], args[i]});
			ev[(i + 1) % 7] = 1'b1;
			step(1);
			ev = 7'h00;
			step(2);
			cmp_val({o_disp_valid, o_disp_code, 8'h00}, {1'b1, codes[i], 8'h00});
			i_io_fault_clear = 1;
			step(1);
			i_io_fault_clear = 0;
			step(2);
		end
		{i_bus_fault, i_bus_err_code, i_bus_err_arg} = {1'b1, 4'h9, 8'h21};
		step(2);
		cmp_val({o_disp_is_io, o_disp_code, o_disp_arg}, {1'b0, 4'h9, 8'h21});
		finish_test();
	end
endmodule // tb_diag_led_encoder

`default_nettype wire
